// [shared/emd_pkg.sv]
/*
 * Constants, state encoding and check-bit arithmetic for the ECC
 * DRAM module datapath.
 * Assumes a 22-bit byte address bus and a 16-bit data word.
 */
package emd_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CHK_W  = 6;
    localparam int WORD_W = DATA_W + CHK_W;
    localparam int BANKS  = 8;
    localparam int AA_W   = 8;

    // check pattern of an all-zero word, also the initial fill value
    localparam logic [CHK_W-1:0] INIT_CHECK = 6'h0c;

    // top i/o page is addr[21:13] all ones; register block below it
    localparam logic [8:0] IO_PAGE_HI = 9'h1ff;
    localparam logic [7:0] CSR_MID    = 8'hf8;
    // module spans 64 blocks of 16K bytes
    localparam logic [7:0] MOD_SPAN   = 8'h40;

    // status register layout
    localparam int CSR_UE     = 15;
    localparam int CSR_VSEL   = 12;
    localparam int CSR_MID_LO = 5;
    localparam int CSR_SE     = 4;
    localparam int CSR_DIAGNOSTIC_CYCLE_DECODER   = 2;
    localparam int CSR_NOCORR = 1;
    localparam logic [15:0] CSR_RST = 16'h0000;

    // array address mux sources
    localparam logic [1:0] AMX_ROW     = 2'h0;
    localparam logic [1:0] AMX_COL     = 2'h1;
    localparam logic [1:0] AMX_REF_ROW = 2'h2;
    localparam logic [1:0] AMX_INI_COL = 2'h3;

    // views of the seven middle status bits
    localparam logic [1:0] VIEW_SYN  = 2'h0;
    localparam logic [1:0] VIEW_BLKL = 2'h1;
    localparam logic [1:0] VIEW_BLKH = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SKIP  = 4'h2,
        ST_MEM   = 4'h4,
        ST_REPLY = 4'h8
    } emd_state_t;

    // hamming position of data bit idx (powers of two hold check bits)
    function automatic logic [4:0] emd_pos(input int idx);
        int p;
        int n;
        logic [4:0] r;
        r = 5'h00;
        n = 0;
        for (p = 3; p < 22; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (n == idx) r = p[4:0];
                n++;
            end
        end
        return r;
    endfunction

    function automatic logic [CHK_W-1:0] emd_check(
        input logic [DATA_W-1:0] d);
        logic [CHK_W-1:0] c;
        c = 6'h00;
        for (int i = 0; i < DATA_W; i++) begin
            if (d[i]) c[4:0] = c[4:0] ^ emd_pos(i);
        end
        c[5] = (^d) ^ (^c[4:0]);
        return c ^ INIT_CHECK;
    endfunction

    // byte offset of an address in 16K units from the start switches
    function automatic logic [7:0] emd_offset(input logic [7:0] hi,
                                              input logic [7:0] start);
        return hi - start;
    endfunction
endpackage

// [rtl/emd_ecc.sv]
/*
 * Error correction unit: syndrome, single-bit repair, error class.
 * Purely combinational; the caller registers its outputs.
 */
`timescale 1ns/10ps
module emd_ecc
    import emd_pkg::*;
(
    input  logic [DATA_W-1:0] rd_data,
    input  logic [CHK_W-1:0]  rd_check,
    output logic [DATA_W-1:0] fixed_data,
    output logic [CHK_W-1:0]  syndrome,
    output logic              err_single,
    output logic              err_double
);
    always_comb begin
        syndrome   = rd_check ^ emd_check(rd_data);
        // overall parity over the whole stored word, not regenerated bits;
        // otherwise odd-weight positions would look like double errors
        syndrome[5] = (^rd_data) ^ (^rd_check);
        fixed_data = rd_data;
        for (int i = 0; i < DATA_W; i++) begin
            // overall parity odd means a single flip, located by code
            if (syndrome[5] && syndrome[4:0] == emd_pos(i))
                fixed_data[i] = ~rd_data[i];
        end
        err_single = syndrome[5];
        err_double = !syndrome[5] && (syndrome[4:0] != 5'h00);
    end
endmodule // emd_ecc

// [rtl/emd_datapath.sv]
/*
 * Address selection and data path of an ECC DRAM memory module.
 * Assumes an external sequencer that issues strobe and capture
 * commands on core_clk, and refresh counters supplying row/column.
 */
`timescale 1ns/10ps
module emd_datapath
    import emd_pkg::*;
(
    input  logic              core_clk,
    input  logic              rstn,
    input  logic [ADDR_W-1:0] bus_addr,
    input  logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0] bus_data_out,
    output logic              bus_data_oe,
    input  logic [1:0]        bus_ctl,
    input  logic              bus_msyn,
    output logic              bus_ssyn,
    input  logic [7:0]        sw_start,
    input  logic [3:0]        sw_csr,
    input  logic              seq_ras,
    input  logic              seq_cas,
    input  logic              seq_we,
    input  logic [1:0]        seq_addr_sel,
    input  logic              seq_rd_cap,
    input  logic              seq_done,
    input  logic              init_ref_sel,
    input  logic              init_mode,
    input  logic [AA_W-1:0]   ref_row,
    input  logic [AA_W-1:0]   init_col,
    output logic              cyc_req,
    output logic              cyc_write,
    output logic              cyc_byte,
    output logic              sel_low32,
    output logic              sel_up16,
    output logic              err_single,
    output logic              err_double,
    output logic              diagnostic_cycle_decoder_mode,
    output logic              nocorr_mode,
    output logic              ue_led,
    output logic [BANKS-1:0]  ras_n,
    output logic              cas_n,
    output logic              we_n,
    output logic [AA_W-1:0]   arr_addr,
    input  logic [WORD_W-1:0] arr_dq_in,
    output logic [WORD_W-1:0] arr_dq_out,
    output logic              arr_dq_oe
);
    logic [ADDR_W-1:0] addr_m_q, addr_s_q;
    logic [DATA_W-1:0] din_m_q,  din_s_q;
    logic [1:0]        ctl_m_q,  ctl_s_q;
    logic              msyn_m_q, msyn_s_q, msyn_p_q;
    logic [7:0]        start_m_q, start_s_q;
    logic [3:0]        swcsr_m_q, swcsr_s_q;
    logic [WORD_W-1:0] dq_m_q,   dq_s_q;

    emd_state_t        st_q;
    logic [4:0]        hi_lat_q;
    logic [7:0]        col_lat_q;
    logic [7:0]        row_lat_q;
    logic              a0_q;
    logic [DATA_W-1:0] data_lat_q;
    logic              csr_cyc_q;
    logic [DATA_W-1:0] rd_fix_q, rd_raw_q;
    logic              ue_q, se_q, diagnostic_cycle_decoder_q, nocorr_q;
    logic [1:0]        view_q;
    logic [11:0]       blk_q;
    logic [CHK_W-1:0]  syn_q, diagnostic_cycle_decoder_chk_q;
    logic              ssyn_q, doe_q, req_q, wr_q, byte_q;
    logic              low32_q, up16_q, es_q, ed_q;
    logic [DATA_W-1:0] dout_q;
    logic [BANKS-1:0]  ras_n_q;
    logic              cas_n_q, we_n_q, dq_oe_q;
    logic [AA_W-1:0]   aa_q;
    logic [WORD_W-1:0] dq_out_q;

    logic              msyn_rise, io_page, mod_hit, csr_hit, wr_like;
    logic [7:0]        off_bus, off_lat;
    logic [2:0]        bank;
    logic [DATA_W-1:0] fix_data, wdata, csr_rd;
    logic [CHK_W-1:0]  syndrome, wchk;
    logic              ecc_single, ecc_double;

    // every pin group passes two flops before any decode reads it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            addr_m_q  <= '0;
            addr_s_q  <= '0;
            din_m_q   <= '0;
            din_s_q   <= '0;
            ctl_m_q   <= 2'h0;
            ctl_s_q   <= 2'h0;
            msyn_m_q  <= 1'b0;
            msyn_s_q  <= 1'b0;
            msyn_p_q  <= 1'b0;
            start_m_q <= 8'h00;
            start_s_q <= 8'h00;
            swcsr_m_q <= 4'h0;
            swcsr_s_q <= 4'h0;
            dq_m_q    <= '0;
            dq_s_q    <= '0;
        end else begin
            addr_m_q  <= bus_addr;
            addr_s_q  <= addr_m_q;
            din_m_q   <= bus_data_in;
            din_s_q   <= din_m_q;
            ctl_m_q   <= bus_ctl;
            ctl_s_q   <= ctl_m_q;
            msyn_m_q  <= bus_msyn;
            msyn_s_q  <= msyn_m_q;
            msyn_p_q  <= msyn_s_q;
            start_m_q <= sw_start;
            start_s_q <= start_m_q;
            swcsr_m_q <= sw_csr;
            swcsr_s_q <= swcsr_m_q;
            dq_m_q    <= arr_dq_in;
            dq_s_q    <= dq_m_q;
        end
    end

    assign msyn_rise = msyn_s_q && !msyn_p_q;

    // select decode on the live synchronised address
    always_comb begin
        off_bus = emd_offset(addr_s_q[21:14], start_s_q);
        io_page = addr_s_q[21:13] == IO_PAGE_HI;
        mod_hit = !io_page && (off_bus < MOD_SPAN);
        csr_hit = io_page && addr_s_q[12:5] == CSR_MID
                  && addr_s_q[4:1] == swcsr_s_q;
    end

    // bank and column from the two latches; start may sit off a bank
    always_comb begin
        off_lat = emd_offset({hi_lat_q, col_lat_q[7:5]}, start_s_q);
        bank    = off_lat[5:3];
    end

    emd_ecc u_ecc (
        .rd_data    (dq_s_q[DATA_W-1:0]),
        .rd_check   (dq_s_q[WORD_W-1:DATA_W]),
        .fixed_data (fix_data),
        .syndrome   (syndrome),
        .err_single (ecc_single),
        .err_double (ecc_double)
    );

    // byte writes merge into the corrected word read earlier
    always_comb begin
        if (init_mode) wdata = 16'h0000;
        else if (!byte_q) wdata = data_lat_q;
        else if (a0_q) wdata = {data_lat_q[15:8], rd_fix_q[7:0]};
        else wdata = {rd_fix_q[15:8], data_lat_q[7:0]};
        if (init_mode) wchk = INIT_CHECK;
        else if (diagnostic_cycle_decoder_q) wchk = diagnostic_cycle_decoder_chk_q;
        else wchk = emd_check(wdata);
        wr_like = wr_q || init_mode;
    end

    always_comb begin
        csr_rd = CSR_RST;
        csr_rd[CSR_UE] = ue_q;
        csr_rd[CSR_VSEL+1:CSR_VSEL] = view_q;
        csr_rd[CSR_SE] = se_q;
        csr_rd[CSR_DIAGNOSTIC_CYCLE_DECODER] = diagnostic_cycle_decoder_q;
        csr_rd[CSR_NOCORR] = nocorr_q;
        // diagnostic view wins so software sees what it loaded
        if (diagnostic_cycle_decoder_q)
            csr_rd[11:5] = {1'b0, diagnostic_cycle_decoder_chk_q};
        else if (view_q == VIEW_BLKL)
            csr_rd[11:5] = blk_q[6:0];
        else if (view_q == VIEW_BLKH)
            csr_rd[11:5] = {2'b00, blk_q[11:7]};
        else
            csr_rd[11:5] = {1'b0, syn_q};
    end

    // bus handshake; unselected cycles are watched but never answered
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q    <= ST_IDLE;
            ssyn_q  <= 1'b0;
            doe_q   <= 1'b0;
            dout_q  <= 16'h0000;
            req_q   <= 1'b0;
        end else begin
            req_q <= 1'b0;
            unique case (st_q)
                ST_IDLE: if (msyn_rise) begin
                    if (csr_hit) begin
                        st_q   <= ST_REPLY;
                        ssyn_q <= 1'b1;
                        doe_q  <= !ctl_s_q[1];
                        dout_q <= csr_rd;
                    end else if (mod_hit) begin
                        st_q  <= ST_MEM;
                        req_q <= 1'b1;
                    end else begin
                        st_q <= ST_SKIP;
                    end
                end
                ST_SKIP: if (!msyn_s_q) st_q <= ST_IDLE;
                ST_MEM: if (seq_done) begin
                    st_q   <= ST_REPLY;
                    ssyn_q <= 1'b1;
                    doe_q  <= !wr_q;
                    dout_q <= nocorr_q ? rd_raw_q : rd_fix_q;
                end
                ST_REPLY: if (!msyn_s_q) begin
                    st_q   <= ST_IDLE;
                    ssyn_q <= 1'b0;
                    doe_q  <= 1'b0;
                end
            endcase
        end
    end

    // address and data latches load once per cycle start
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hi_lat_q   <= 5'h00;
            col_lat_q  <= 8'h00;
            row_lat_q  <= 8'h00;
            a0_q       <= 1'b0;
            data_lat_q <= 16'h0000;
            csr_cyc_q  <= 1'b0;
            wr_q       <= 1'b0;
            byte_q     <= 1'b0;
            low32_q    <= 1'b0;
            up16_q     <= 1'b0;
        end else if (st_q == ST_IDLE && msyn_rise) begin
            hi_lat_q   <= addr_s_q[21:17];
            col_lat_q  <= addr_s_q[16:9];
            row_lat_q  <= addr_s_q[8:1];
            a0_q       <= addr_s_q[0];
            data_lat_q <= din_s_q;
            csr_cyc_q  <= csr_hit;
            wr_q       <= ctl_s_q[1];
            byte_q     <= ctl_s_q == 2'h3;
            low32_q    <= mod_hit && off_bus[7:1] == 7'h00;
            up16_q     <= off_bus[0];
        end
    end

    // array strobes; one clock of skew keeps we ahead of cas
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ras_n_q  <= 8'hff;
            cas_n_q  <= 1'b1;
            we_n_q   <= 1'b1;
            aa_q     <= 8'h00;
            dq_out_q <= '0;
            dq_oe_q  <= 1'b0;
        end else begin
            if (!seq_ras) ras_n_q <= 8'hff;
            else if (init_ref_sel) ras_n_q <= 8'h00;
            else ras_n_q <= ~(8'h01 << bank);
            we_n_q  <= !(seq_we && wr_like);
            cas_n_q <= !(seq_cas && (!wr_like || !we_n_q));
            unique case (seq_addr_sel)
                AMX_ROW:     aa_q <= row_lat_q;
                AMX_COL:     aa_q <= {off_lat[2:0], col_lat_q[4:0]};
                AMX_REF_ROW: aa_q <= ref_row;
                AMX_INI_COL: aa_q <= init_col;
            endcase
            dq_out_q <= {wchk, wdata};
            dq_oe_q  <= seq_we && wr_like;
        end
    end

    // read capture, error class to the sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_fix_q <= 16'h0000;
            rd_raw_q <= 16'h0000;
            es_q     <= 1'b0;
            ed_q     <= 1'b0;
        end else if (req_q) begin
            es_q <= 1'b0;
            ed_q <= 1'b0;
        end else if (seq_rd_cap) begin
            rd_fix_q <= fix_data;
            rd_raw_q <= dq_s_q[DATA_W-1:0];
            es_q     <= ecc_single;
            ed_q     <= ecc_double;
        end
    end

    // status register; hardware sets override a same-cycle clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ue_q       <= 1'b0;
            se_q       <= 1'b0;
            diagnostic_cycle_decoder_q     <= 1'b0;
            nocorr_q   <= 1'b0;
            view_q     <= VIEW_SYN;
            blk_q      <= 12'h000;
            syn_q      <= 6'h00;
            diagnostic_cycle_decoder_chk_q <= 6'h00;
        end else begin
            if (st_q == ST_IDLE && msyn_rise && csr_hit
                && ctl_s_q[1]) begin
                ue_q     <= ue_q && din_s_q[CSR_UE];
                se_q     <= se_q && din_s_q[CSR_SE];
                diagnostic_cycle_decoder_q   <= din_s_q[CSR_DIAGNOSTIC_CYCLE_DECODER];
                nocorr_q <= din_s_q[CSR_NOCORR];
                view_q   <= din_s_q[CSR_VSEL+1:CSR_VSEL];
                if (din_s_q[CSR_DIAGNOSTIC_CYCLE_DECODER])
                    diagnostic_cycle_decoder_chk_q <= din_s_q[10:5];
            end
            // a logged double error locks the log until cleared
            if (seq_rd_cap && !diagnostic_cycle_decoder_q && !ue_q
                && (ecc_single || ecc_double)) begin
                blk_q <= {hi_lat_q, col_lat_q[7:1]};
                syn_q <= syndrome;
                if (ecc_single) se_q <= 1'b1;
                if (ecc_double) ue_q <= 1'b1;
            end
        end
    end

    assign bus_data_out = dout_q;
    assign bus_data_oe  = doe_q;
    assign bus_ssyn     = ssyn_q;
    assign cyc_req      = req_q;
    assign cyc_write    = wr_q;
    assign cyc_byte     = byte_q;
    assign sel_low32    = low32_q;
    assign sel_up16     = up16_q;
    assign err_single   = es_q;
    assign err_double   = ed_q;
    assign diagnostic_cycle_decoder_mode    = diagnostic_cycle_decoder_q;
    assign nocorr_mode  = nocorr_q;
    assign ue_led       = ue_q;
    assign ras_n        = ras_n_q;
    assign cas_n        = cas_n_q;
    assign we_n         = we_n_q;
    assign arr_addr     = aa_q;
    assign arr_dq_out   = dq_out_q;
    assign arr_dq_oe    = dq_oe_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_ras_one_bank: assert property (
        seq_ras && !init_ref_sel |=> $onehot(~ras_n_q))
        else $error("more or less than one ras bank active");
    a_ras_all_banks: assert property (
        seq_ras && init_ref_sel |=> ras_n_q == 8'h00)
        else $error("init or refresh did not strobe all banks");
    a_doe_read_only: assert property (
        doe_q |-> ssyn_q && !wr_q)
        else $error("bus data driven outside a read reply");
    a_we_before_cas: assert property (
        $fell(cas_n_q) && wr_like |-> $past(!we_n_q))
        else $error("cas fell before write enable on a write");
    a_read_no_we: assert property (
        !wr_like |=> we_n_q && !dq_oe_q)
        else $error("write enable or data drive on a read");
    a_bank_addr_hold: assert property (
        st_q == ST_MEM && $past(st_q) == ST_MEM |-> $stable(hi_lat_q)
        && $stable(col_lat_q))
        else $error("latched address moved during a cycle");
    a_reply_selected: assert property (
        $rose(ssyn_q) |-> $past(st_q == ST_MEM || csr_hit))
        else $error("reply to a cycle that was not selected");
    a_ssyn_release: assert property (
        ssyn_q && !msyn_s_q |=> !ssyn_q)
        else $error("reply held after master released");
    a_err_log: assert property (
        seq_rd_cap && !req_q && !diagnostic_cycle_decoder_q && !ue_q && ecc_double
        |=> ue_q && syn_q == $past(syndrome))
        else $error("double error not logged");
    a_init_pattern: assert property (
        init_mode && seq_we |=> dq_oe_q && dq_out_q == {INIT_CHECK, 16'h0000})
        else $error("init write pattern wrong");

    c_mem_read: cover property (
        st_q == ST_MEM && !wr_q ##[1:100] $rose(ssyn_q));
    c_mem_write: cover property ($fell(we_n_q) ##[1:8] $fell(cas_n_q));
    c_single_fix: cover property (seq_rd_cap && ecc_single);
    c_csr_access: cover property (st_q == ST_IDLE && msyn_rise && csr_hit);
endmodule // emd_datapath

// [test/emd_bus_master.sv]
/*
 * Bus master model: one address/data transfer with a level handshake.
 * Assumes the slave answers within sixty core_clk cycles.
 */
`timescale 1ns/10ps
module emd_bus_master
    import emd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              bus_ssyn,
    input  wire logic [DATA_W-1:0] bus_data_out,
    output logic      [ADDR_W-1:0] bus_addr,
    output logic      [DATA_W-1:0] bus_data_in,
    output logic      [1:0]        bus_ctl,
    output logic                   bus_msyn
);
    initial begin
        bus_addr = '0;
        bus_data_in = '0;
        bus_ctl = 2'h0;
        bus_msyn = 1'b0;
    end

    // address settles a cycle ahead of sync; skew on real cables
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic [1:0] c,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output bit ok);
        int n;
        @(posedge core_clk) #1;
        bus_addr = a;
        bus_ctl = c;
        bus_data_in = c[1] ? d : ~bus_data_in;
        @(posedge core_clk) #1;
        bus_msyn = 1'b1;
        ok = 1'b0;
        for (n = 0; n < 60 && !ok; n++) begin
            @(posedge core_clk) #1;
            ok = (bus_ssyn === 1'b1);
        end
        q = bus_data_out;
        bus_msyn = 1'b0;
        for (n = 0; n < 10 && bus_ssyn !== 1'b0; n++) begin
            @(posedge core_clk) #1;
        end
        // released lines must not keep a stale value
        bus_addr = ~a;
        bus_data_in = ~bus_data_in;
    endtask
endmodule // emd_bus_master

// [test/emd_datapath_tb_top.sv]
/*
 * Bench for the module datapath: plays the sequencer and a one-word
 * array. Assumes the bus master model in its own file.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module emd_datapath_tb_top
    import emd_pkg::*;
;
    localparam logic [ADDR_W-1:0] CSR_A = {9'h1ff, 8'hf8, 4'h5, 1'b0};
    localparam logic [ADDR_W-1:0] MA    = {8'h18, 14'h0a40};
    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              bus_msyn, bus_ssyn, bus_data_oe, cyc_req, cyc_write;
    logic              seq_ras, seq_cas, seq_we, seq_rd_cap, seq_done;
    logic              init_ref_sel, init_mode, cyc_byte, sel_low32;
    logic              sel_up16, err_single, err_double, diagnostic_cycle_decoder_mode;
    logic              nocorr_mode, ue_led, cas_n, we_n, arr_dq_oe;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_data_in, bus_data_out, q;
    logic [1:0]        bus_ctl, seq_addr_sel;
    logic [3:0]        sw_csr;
    logic [7:0]        sw_start, ras_n, ref_row, init_col, arr_addr;
    logic [WORD_W-1:0] arr_dq_in, arr_dq_out, mem_word, flip;
    bit                ok;
    int                failures = 0;
    int                samples_checked = 0;
    logic [31:0]       rows [5] = '{32'h0002_0002, 32'h1000_1000,
        32'h2000_2000, 32'h0f69_0000, 32'h8010_0000};

    always #10 core_clk = ~core_clk;
    // ram answers whenever read; flip injects bad bits
    assign arr_dq_in = mem_word ^ flip;

    emd_datapath DUT (.*);
    emd_bus_master m (.*);

    always @(posedge core_clk)
        if (bus_data_oe === 1'b1 && bus_ctl[1] === 1'b1)
            `CHK("oe_on_write", 1'b0, bus_data_oe)

    task automatic seq_run(input bit rd);
        int n;
        for (n = 0; n < 40 && cyc_req !== 1'b1; n++) @(posedge core_clk) #1;
        `CHK("cyc_write", !rd, cyc_write)
        seq_addr_sel = AMX_ROW;
        seq_ras = 1'b1;
        @(posedge core_clk) #1;
        seq_addr_sel = AMX_COL;
        seq_we = !rd;
        @(posedge core_clk) #1;
        seq_cas = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("ras_n", 8'hfd, ras_n)
        `CHK("arr_addr", MA[16:9], arr_addr)
        `CHK("we_n", rd, we_n)
        `CHK("cas_n", 1'b0, cas_n)
        if (!rd) mem_word = arr_dq_out;
        // array data crosses two sync flops before capture
        repeat (3) @(posedge core_clk);
        #1;
        seq_rd_cap = rd;
        @(posedge core_clk) #1;
        {seq_rd_cap, seq_ras, seq_cas, seq_we} = 4'h0;
        seq_done = 1'b1;
        @(posedge core_clk) #1;
        seq_done = 1'b0;
    endtask

    task automatic mem_op(input logic [1:0] c, input logic [DATA_W-1:0] d);
        fork
            m.xfer(MA, c, d, q, ok);
            seq_run(!c[1]);
        join
    endtask

    task automatic reg_op(input logic [1:0] c, input logic [DATA_W-1:0] d);
        m.xfer(CSR_A, c, d, q, ok);
    endtask

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {seq_ras, seq_cas, seq_we, seq_rd_cap, seq_done} = 5'h00;
        {init_ref_sel, init_mode} = 2'h0;
        seq_addr_sel = AMX_ROW;
        sw_start = 8'h10;
        sw_csr = 4'h5;
        ref_row = 8'h3c;
        init_col = 8'hc3;
        mem_word = '0;
        flip = '0;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("rst_ras", 8'hff, ras_n)
        `CHK("rst_oe", 1'b0, bus_data_oe)
        rstn = 1'b1;
        end_test("reset");
        for (int i = 0; i < 5; i++) begin
            reg_op(2'h2, rows[i][31:16]);
            reg_op(2'h0, 16'h0000);
            `CHK("csr", rows[i][15:0], q)
            `CHK("nocorr", rows[i][17], nocorr_mode)
        end
        end_test("csr table");
        mem_op(2'h2, 16'h0000);
        `CHK("zero_word", {6'h0c, 16'h0000}, mem_word)
        `CHK("low32", 1'b0, sel_low32)
        `CHK("up16", 1'b0, sel_up16)
        `CHK("byte", 1'b0, cyc_byte)
        mem_op(2'h2, 16'ha5c3);
        mem_op(2'h0, 16'h0000);
        `CHK("read", 16'ha5c3, q)
        `CHK("no_err", 2'b00, {err_single, err_double})
        end_test("write read");
        flip = 22'h8;
        mem_op(2'h0, 16'h0000);
        `CHK("fixed", 16'ha5c3, q)
        `CHK("single", 1'b1, err_single)
        reg_op(2'h0, 16'h0000);
        `CHK("se_bit", 1'b1, q[4])
        reg_op(2'h2, 16'h1000);
        reg_op(2'h0, 16'h0000);
        `CHK("blk_low", MA[16:10], q[11:5])
        end_test("single error");
        flip = 22'h30;
        mem_op(2'h0, 16'h0000);
        `CHK("double", 1'b1, err_double)
        `CHK("ue_led", 1'b1, ue_led)
        reg_op(2'h2, 16'h0000);
        `CHK("ue_clear", 1'b0, ue_led)
        flip = '0;
        end_test("double error");
        reg_op(2'h2, 16'h0544);
        `CHK("diagnostic_cycle_decoder", 1'b1, diagnostic_cycle_decoder_mode)
        mem_op(2'h2, 16'h0000);
        `CHK("diagnostic_cycle_decoder_chk", 6'h2a, mem_word[21:16])
        reg_op(2'h2, 16'h0000);
        end_test("diagnostic_cycle_decoder");
        m.xfer({8'h50, 14'h0000}, 2'h0, 16'h0000, q, ok);
        `CHK("refused", 1'b0, ok)
        end_test("refused");
        init_ref_sel = 1'b1;
        seq_ras = 1'b1;
        seq_addr_sel = AMX_REF_ROW;
        repeat (2) @(posedge core_clk) #1;
        `CHK("all_banks", 8'h00, ras_n)
        `CHK("ref_row", 8'h3c, arr_addr)
        seq_addr_sel = AMX_INI_COL;
        init_mode = 1'b1;
        seq_we = 1'b1;
        repeat (2) @(posedge core_clk) #1;
        `CHK("init_col", 8'hc3, arr_addr)
        `CHK("init_word", {6'h0c, 16'h0000}, arr_dq_out)
        `CHK("init_we", 1'b0, we_n)
        `CHK("init_oe", 1'b1, arr_dq_oe)
        {seq_ras, seq_we, init_mode, init_ref_sel} = 4'h0;
        end_test("init");
        finish_test;
    end

    // whole run needs about three hundred cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        finish_test;
    end
endmodule // emd_datapath_tb_top
